/* File: rtl/typeb_pkg.sv */
/*
 * constants for the type b answer and attrib handler: frame codes, field values,
 * lengths and crc figures.
 * assumes nothing of its surroundings; imported by the design modules.
 */
package typeb_pkg;
    // ----------------------------------------
    // frame codes and fixed field values
    // ----------------------------------------
    localparam logic [7:0] ATQB_CODE = 8'h50;
    localparam logic [7:0] ATTRIB_CODE = 8'h1D;
    localparam logic [7:0] APP_DATA_BYTE = 8'h00;
    localparam logic [7:0] PI1_HIGH_SPEED = 8'hB3;
    localparam logic [7:0] PI1_BASE_SPEED = 8'h80;
    localparam logic [7:0] PI2_FRAME_PROTO = 8'h81;
    localparam logic [3:0] PI3_LOW_NIBBLE = 4'h0;
    localparam logic [7:0] ATTRIB_ANSWER = 8'h10;
    localparam logic [1:0] PARAM_RFU_CODE = 2'h3;
    localparam logic [1:0] PARAM_DEFAULT_CODE = 2'h0;
    localparam logic [1:0] RATE_106 = 2'h0;
    localparam logic [3:0] MAX_PCD_FRAME_CODE = 4'h8;
    // ----------------------------------------
    // lengths and positions, counted in bytes, crc excluded except in ATTRIB_FRAME_LEN
    // ----------------------------------------
    localparam logic [3:0] ATQB_DATA_LEN = 4'hC;
    localparam logic [3:0] ATTRIB_DATA_LEN = 4'h1;
    localparam logic [3:0] ATTRIB_FRAME_LEN = 4'hB;
    localparam logic [3:0] P1_POS = 4'h5;
    localparam logic [3:0] P2_POS = 4'h6;
    localparam logic [3:0] P3_POS = 4'h7;
    // ----------------------------------------
    // crc_b: reflected 0x1021, preset ffff, sent inverted, low byte first
    // ----------------------------------------
    localparam logic [15:0] CRC_PRESET = 16'hFFFF;
    localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
    localparam logic [15:0] CRC_RESIDUE = 16'hF0B8;
    // ----------------------------------------
    // handler states
    // ----------------------------------------
    typedef enum logic [0:0] {ST_IDLE, ST_SEND} state_e;
endpackage

/* File: rtl/crc_b_step.sv */
/*
 * one byte step of the crc_b register, combinational.
 * assumes bytes are presented least significant bit first on the air.
 */
`timescale 1ns/1ns
module crc_b_step (
    input wire logic [15:0] crc_in,
    input wire logic [7:0] data,
    output logic [15:0] crc_out
);
    import typeb_pkg::*;
    always_comb begin
        logic [15:0] c;
        c = crc_in;
        for (int i = 0; i < 8; i++) begin
            if (c[0] ^ data[i]) begin
                c = (c >> 1) ^ CRC_POLY_REFL;
            end else begin
                c = c >> 1;
            end
        end
        crc_out = c;
    end
endmodule // crc_b_step

/* File: rtl/type_b_atqb_attrib_handler.sv */
/*
 * type b answer builder and attrib interpreter for a contactless tag.
 * assumes a framer on the same clock delivering received bytes with frame
 * start/end pulses and taking transmit bytes on a valid/ready handshake.
 */
// Overview of operation
// - answer application data is four zero bytes
// - speed limit 0 and high speed enabled: first protocol byte b3
// - speed limit 1: first protocol byte 80, 106 kbps only
// - second protocol byte is 81: 256-byte frame, block protocol
// - third protocol byte carries configured fwi in bits 7-4
// - third protocol byte low nibble is zero
// - accepted attrib moves the tag into the active state
// - param1 bits 7-6 of 11 taken as 00
// - param1 bits 5-4 of 11 taken as 00
// - param1 bits 3-0 ignored; fixed 64/fs, 80/fs, sof and eof kept
// - accepted attrib answered by 10 plus crc_b
// - unequal or unsupported rates or frame size: no answer
// - param3 bits 7-4 zero and bit 0 set, else no answer
`timescale 1ns/1ns
module type_b_atqb_attrib_handler (
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] pupi,
    input wire logic [3:0] fwi,
    input wire logic rf_speed_limit,
    input wire logic type_b_high_speed_enable,
    input wire logic send_atqb,
    input wire logic rx_sof,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_eof,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    output logic tx_last,
    output logic active,
    output logic [1:0] tr0_code,
    output logic [1:0] tr1_code,
    output logic frame_marks_on
);
    import typeb_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        state_e st;
        logic active;
        logic [3:0] rx_cnt;
        logic rx_over;
        logic [15:0] rx_crc;
        logic [7:0] cmd;
        logic [31:0] id;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] p3;
        logic tx_attr;
        logic [3:0] tx_idx;
        logic [15:0] tx_crc;
        logic [7:0] tx_byte;
        logic tx_valid;
        logic tx_last;
        logic [1:0] tr0;
        logic [1:0] tr1;
        logic marks;
    } state_s;

    state_s s_reg;
    state_s s_next;
    logic [15:0] rx_crc_step;
    logic [15:0] tx_crc_step;
    logic [7:0] data_sel;
    logic [7:0] pi1;
    logic [3:0] data_len;
    logic load;
    logic rates_ok;
    logic attrib_ok;

    crc_b_step rx_crc_u (
        .crc_in(s_reg.rx_crc),
        .data(rx_byte),
        .crc_out(rx_crc_step)
    );

    crc_b_step tx_crc_u (
        .crc_in(s_reg.tx_crc),
        .data(data_sel),
        .crc_out(tx_crc_step)
    );

    // ----------------------------------------
    // answer contents
    // ----------------------------------------
    always_comb begin
        // with high speed off and no limit the tag still offers only 106 kbps
        if (!rf_speed_limit && type_b_high_speed_enable) begin
            pi1 = PI1_HIGH_SPEED;
        end else begin
            pi1 = PI1_BASE_SPEED;
        end
        data_len = s_reg.tx_attr ? ATTRIB_DATA_LEN : ATQB_DATA_LEN;
        data_sel = APP_DATA_BYTE;
        if (s_reg.tx_attr) begin
            data_sel = ATTRIB_ANSWER;
        end else begin
            case (s_reg.tx_idx)
                4'h0: data_sel = ATQB_CODE;
                4'h1: data_sel = pupi[31:24];
                4'h2: data_sel = pupi[23:16];
                4'h3: data_sel = pupi[15:8];
                4'h4: data_sel = pupi[7:0];
                4'h9: data_sel = pi1;
                4'hA: data_sel = PI2_FRAME_PROTO;
                4'hB: data_sel = {fwi, PI3_LOW_NIBBLE};
                default: data_sel = APP_DATA_BYTE;
            endcase
        end
    end

    // ----------------------------------------
    // attrib acceptance
    // ----------------------------------------
    always_comb begin
        // only rates the answer advertised are accepted, and only equal ones
        rates_ok = (s_reg.p2[7:6] == s_reg.p2[5:4]) && (s_reg.p2[7:6] != PARAM_RFU_CODE)
            && ((s_reg.p2[7:6] == RATE_106) || (pi1 == PI1_HIGH_SPEED));
        attrib_ok = rx_eof && !s_reg.rx_over && (s_reg.rx_cnt == ATTRIB_FRAME_LEN)
            && (s_reg.rx_crc == CRC_RESIDUE)
            && (s_reg.cmd == ATTRIB_CODE) && (s_reg.id == pupi)
            && rates_ok && (s_reg.p2[3:0] <= MAX_PCD_FRAME_CODE)
            && (s_reg.p3[7:4] == 4'h0) && s_reg.p3[0];
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_next = s_reg;
        load = (s_reg.st == ST_SEND) && (!s_reg.tx_valid || tx_ready);
        if (rx_sof) begin
            s_next.rx_cnt = 4'h0;
            s_next.rx_over = 1'b0;
            s_next.rx_crc = CRC_PRESET;
        end else if (rx_valid) begin
            s_next.rx_crc = rx_crc_step;
            if (s_reg.rx_cnt == ATTRIB_FRAME_LEN) begin
                s_next.rx_over = 1'b1;
            end else begin
                s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
            end
            case (s_reg.rx_cnt)
                4'h0: s_next.cmd = rx_byte;
                4'h1: s_next.id[31:24] = rx_byte;
                4'h2: s_next.id[23:16] = rx_byte;
                4'h3: s_next.id[15:8] = rx_byte;
                4'h4: s_next.id[7:0] = rx_byte;
                P1_POS: s_next.p1 = rx_byte;
                P2_POS: s_next.p2 = rx_byte;
                P3_POS: s_next.p3 = rx_byte;
                default: s_next.cmd = s_next.cmd;
            endcase
        end
        case (s_reg.st)
            ST_IDLE: begin
                // once active, higher-layer logic owns the link; attrib is no longer taken
                if (attrib_ok && !s_reg.active) begin
                    s_next.active = 1'b1;
                    s_next.tr0 = (s_reg.p1[7:6] == PARAM_RFU_CODE) ?
                        PARAM_DEFAULT_CODE : s_reg.p1[7:6];
                    s_next.tr1 = (s_reg.p1[5:4] == PARAM_RFU_CODE) ?
                        PARAM_DEFAULT_CODE : s_reg.p1[5:4];
                    s_next.st = ST_SEND;
                    s_next.tx_attr = 1'b1;
                    s_next.tx_idx = 4'h0;
                    s_next.tx_crc = CRC_PRESET;
                end else if (send_atqb) begin
                    s_next.st = ST_SEND;
                    s_next.tx_attr = 1'b0;
                    s_next.tx_idx = 4'h0;
                    s_next.tx_crc = CRC_PRESET;
                end
            end
            ST_SEND: begin
                if (load) begin
                    if (s_reg.tx_idx == data_len + 4'h2) begin
                        s_next.tx_valid = 1'b0;
                        s_next.tx_last = 1'b0;
                        s_next.st = ST_IDLE;
                    end else begin
                        s_next.tx_valid = 1'b1;
                        s_next.tx_idx = s_reg.tx_idx + 4'h1;
                        s_next.tx_last = (s_reg.tx_idx == data_len + 4'h1);
                        if (s_reg.tx_idx < data_len) begin
                            s_next.tx_byte = data_sel;
                            s_next.tx_crc = tx_crc_step;
                        end else if (s_reg.tx_idx == data_len) begin
                            s_next.tx_byte = ~s_reg.tx_crc[7:0];
                        end else begin
                            s_next.tx_byte = ~s_reg.tx_crc[15:8];
                        end
                    end
                end
            end
            default: s_next.st = ST_IDLE;
        endcase
        // the framer always timed 64/fs and 80/fs and always frames with sof and eof
        s_next.marks = 1'b1;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tx_valid = s_reg.tx_valid;
    assign tx_byte = s_reg.tx_byte;
    assign tx_last = s_reg.tx_last;
    assign active = s_reg.active;
    assign tr0_code = s_reg.tr0;
    assign tr1_code = s_reg.tr1;
    assign frame_marks_on = s_reg.marks;
endmodule // type_b_atqb_attrib_handler

/* File: dv/typeb_handler_assertions.sv */
/* checker for the type b answer and attrib handler ports.
   assumes bind onto the handler; one clock, rst synchronous high. */
`timescale 1ns/1ns
module typeb_handler_assertions
    import typeb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] fwi,
    input wire logic rf_speed_limit,
    input wire logic type_b_high_speed_enable,
    input wire logic rx_eof,
    input wire logic tx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_last,
    input wire logic active,
    input wire logic [1:0] tr0_code,
    input wire logic [1:0] tr1_code,
    input wire logic frame_marks_on
);
    // ----------------------------------------
    // byte index within the frame being sent
    // ----------------------------------------
    logic [3:0] cnt_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= 4'h0;
        end else if (tx_valid && tx_ready) begin
            cnt_reg <= tx_last ? 4'h0 : cnt_reg + 4'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_hold_stall: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("tx byte moved while stalled");
    a_active_sticky: assert property (active |=> active) else $error("active dropped");
    a_no_rfu: assert property (tr0_code != 2'h3 && tr1_code != 2'h3)
        else $error("reserved timing code kept");
    a_marks_on: assert property (!rst |=> frame_marks_on) else $error("frame marks off");
    a_app_zero: assert property (tx_valid && cnt_reg inside {[4'h5:4'h8]} |-> tx_byte == 8'h00)
        else $error("app data not zero");
    a_pi1_value: assert property (tx_valid && cnt_reg == 4'h9 |-> tx_byte ==
        (!rf_speed_limit && type_b_high_speed_enable ? 8'hB3 : 8'h80)) else $error("pi1 wrong");
    a_pi2_value: assert property (tx_valid && cnt_reg == 4'hA |-> tx_byte == 8'h81)
        else $error("pi2 wrong");
    a_pi3_value: assert property (tx_valid && cnt_reg == 4'hB |-> tx_byte == {fwi, 4'h0})
        else $error("pi3 wrong");
    a_attrib_answer: assert property ($rose(active) |-> $past(rx_eof) ##1
        tx_valid && tx_byte == 8'h10) else $error("attrib answer wrong");
    c_atqb_sent: cover property (tx_valid && tx_ready && cnt_reg == 4'hD);
    c_activated: cover property ($rose(active));
    c_stalled: cover property (tx_valid && !tx_ready);
endmodule // typeb_handler_assertions
bind type_b_atqb_attrib_handler typeb_handler_assertions chk_i (.*);

/* File: dv/reader_model.sv */
/* reader side: sends command frames, takes answer bytes with optional stalls.
   assumes the bench fills a frame and calls send. */
`timescale 1ns/1ns
module reader_model #(parameter int GAP = 1321) (
    input wire logic clk,
    input wire logic slow,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_last,
    output logic tx_ready,
    output logic rx_sof,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_eof
);
    // ----------------------------------------
    // answer sink and command source
    // ----------------------------------------
    logic [7:0] got [$];
    logic last_seen [$];
    logic [1:0] cyc = 2'h0;
    initial {tx_ready, rx_sof, rx_valid, rx_byte, rx_eof} = 12'h000;
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_byte);
            last_seen.push_back(tx_last);
        end
        cyc <= cyc + 2'h1;
        tx_ready <= !slow || cyc[1];
    end
    task automatic send(input logic [7:0] f [0:13]);
        repeat (GAP) @(posedge clk);
        rx_sof <= 1'b1;
        @(posedge clk) rx_sof <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            rx_valid <= 1'b1;
            rx_byte <= f[i];
            @(posedge clk);
        end
        rx_valid <= 1'b0;
        rx_byte <= ~f[10];
        rx_eof <= 1'b1;
        @(posedge clk) rx_eof <= 1'b0;
    endtask
endmodule // reader_model

/* File: dv/type_b_atqb_attrib_handler_tb.sv */
/* self-checking bench for the type b handler with the reader model.
   assumes the checker is bound by its own file. */
`timescale 1ns/1ns
module type_b_atqb_attrib_handler_tb;
    // ----------------------------------------
    // stimulus and checks
    // ----------------------------------------
    logic clk = 0, rst = 1, hs = 0, lim = 0, send_atqb = 0, slow = 0;
    logic [31:0] pupi = 32'h0;
    logic [3:0] fwi = 4'h0;
    logic tx_ready, rx_sof, rx_valid, rx_eof, tx_valid, tx_last, active, marks;
    logic [7:0] rx_byte, tx_byte;
    logic [1:0] tr0, tr1;
    logic [7:0] f [0:13];
    logic [15:0] s = 16'h0027;
    int err_count = 0, num_checks = 0;
    always #50 clk = ~clk;
    type_b_atqb_attrib_handler type_b_atqb_attrib_handler_i (.clk(clk), .rst(rst), .pupi(pupi),
        .fwi(fwi), .rf_speed_limit(lim), .type_b_high_speed_enable(hs), .send_atqb(send_atqb),
        .rx_sof(rx_sof), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_eof(rx_eof),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
        .active(active), .tr0_code(tr0), .tr1_code(tr1), .frame_marks_on(marks));
    reader_model reader_model_i (.clk(clk), .slow(slow), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .tx_last(tx_last), .tx_ready(tx_ready), .rx_sof(rx_sof), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_eof(rx_eof));
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [15:0] crc_b(input logic [7:0] b [0:13], input int n);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 0; i < n; i++) begin
            c = c ^ {8'h00, b[i]};
            for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
        end
        return ~c;
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wait_bytes(input int n);
        for (int t = 0; t < 2000 && reader_model_i.got.size() < n; t++) @(posedge clk);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        end_sim;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            s = lfsr(s);
            pupi <= {s, ~s};
            fwi <= s[3:0];
            {lim, hs, slow} <= {k[1], k[0], k[0]};
            @(posedge clk) send_atqb <= 1'b1;
            @(posedge clk) send_atqb <= 1'b0;
            f = '{8'h50, pupi[31:24], pupi[23:16], pupi[15:8], pupi[7:0], 8'h00, 8'h00, 8'h00,
                8'h00, (!lim && hs) ? 8'hB3 : 8'h80, 8'h81, {fwi, 4'h0}, 8'h00, 8'h00};
            {f[13], f[12]} = crc_b(f, 12);
            wait_bytes(14);
            for (int i = 0; i < 14; i++) check("atqb", reader_model_i.got[i], f[i]);
            check("atqb last", {6'h00, reader_model_i.last_seen[12],
                reader_model_i.last_seen[13]}, 8'h01);
            reader_model_i.got.delete();
            reader_model_i.last_seen.delete();
        end
        // each bad variant must leave the tag silent; the last one is accepted
        for (int v = 0; v < 5; v++) begin
            s = lfsr(s);
            f = '{8'h1D, pupi[31:24], pupi[23:16], pupi[15:8], pupi[7:0], 8'hFF,
                v == 1 ? 8'h18 : 8'h08, v == 0 ? 8'h00 : v == 2 ? 8'h11 : 8'h01, 8'h00,
                8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
            {f[10], f[9]} = crc_b(f, 9) ^ (v == 3 ? s : 16'h0000);
            reader_model_i.send(f);
            wait_bytes(3);
            check("answer count", 8'(reader_model_i.got.size()), v == 4 ? 8'h03 : 8'h00);
            check("active", {7'h00, active}, {7'h00, v == 4});
        end
        f[0] = 8'h10;
        {f[2], f[1]} = crc_b(f, 1);
        for (int i = 0; i < 3; i++) check("attrib answer", reader_model_i.got[i], f[i]);
        check("attrib last", {5'h00, reader_model_i.last_seen[0], reader_model_i.last_seen[1],
            reader_model_i.last_seen[2]}, 8'h01);
        check("timing codes", {4'h0, tr0, tr1}, 8'h00);
        check("frame marks", {7'h00, marks}, 8'h01);
        // a mid-run reset must drop active; a second attrib then carries plain timing codes
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("active after reset", {7'h00, active}, 8'h00);
        reader_model_i.got.delete();
        reader_model_i.last_seen.delete();
        f = '{8'h1D, pupi[31:24], pupi[23:16], pupi[15:8], pupi[7:0], 8'h9C, 8'h08,
            8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        {f[10], f[9]} = crc_b(f, 9);
        reader_model_i.send(f);
        wait_bytes(3);
        check("second answer count", 8'(reader_model_i.got.size()), 8'h03);
        check("second active", {7'h00, active}, 8'h01);
        check("second timing codes", {4'h0, tr0, tr1}, 8'h09);
        check("frame marks kept", {7'h00, marks}, 8'h01);
        end_sim;
    end
endmodule // type_b_atqb_attrib_handler_tb
